// file: rtl/cdd_clock_dist.sv
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module cdd_clock_dist
  import cdd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sync_pin,
  input wire logic oscillator_reference_input,
  input wire logic first_loop_reference_input,
  input wire logic external_feedback_input,
  input wire logic loss_of_signal,
  input wire logic first_loop_lock,
  input wire logic second_loop_lock,
  input wire logic vtune_rail,
  input wire logic input_select_pin_one_i,
  output logic input_select_pin_one_o,
  output logic input_select_pin_one_oe,
  output logic input_select_pin_zero,
  output logic lock_status_pin_one,
  output logic lock_status_pin_two,
  output logic [1:0] active_input_select,
  output logic [NUM_OUTS-1:0] clk_out,
  output logic [NUM_OUTS-1:0] half_step_out,
  output logic reference_buffer_output,
  output logic second_loop_fb_out,
  output logic first_loop_fb_out
);

  // ************************************************************
  // pin resampling
  // ************************************************************
  logic [8:0] pin_s1;
  logic [8:0] pin_s2;
  wire [8:0] pin_raw = {input_select_pin_one_i, vtune_rail, second_loop_lock, first_loop_lock,
                        loss_of_signal, external_feedback_input, first_loop_reference_input,
                        oscillator_reference_input, sync_pin};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 9'h000;
      pin_s2 <= 9'h000;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  wire sync_s = pin_s2[0];
  wire osc_s = pin_s2[1];
  wire ext_fb_s = pin_s2[3];
  wire los_s = pin_s2[4];
  wire lock1_s = pin_s2[5];
  wire lock2_s = pin_s2[6];
  wire vtune_s = pin_s2[7];
  wire pin1_s = pin_s2[8];

  // ************************************************************
  // register file
  // ************************************************************
  cdd_ctrl_t ctrl;
  cdd_sref_t sref;
  cdd_fbdiv_t fbdiv;
  logic [7:0] sync_dis;
  logic [15:0] stat_sel;
  cdd_pair_cfg_t pair_cfg [NUM_PAIRS];
  logic [7:0] dyn_steps;
  logic [NUM_PAIRS-1:0] dyn_mask;
  logic [NUM_PAIRS-1:0] dyn_half_phase;
  logic [12:0] stall_cnt;
  logic sync_prev;
  logic [NUM_PAIRS-1:0] dclk_vec;
  logic sysref_raw;
  logic sref_wrap;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  wire access = psel & penable;
  wire wr = access & pready & pwrite;
  wire pair_hit = (paddr[7:5] == PAIR_PAGE) && (paddr[4:2] < 3'(NUM_PAIRS)) && (paddr[1:0] == 2'b00);
  wire [2:0] pair_idx = paddr[4:2];
  wire hit_ctrl = paddr == CTRL_OFF;
  wire hit_sref = paddr == SREF_OFF;
  wire hit_sdis = paddr == SYNC_DIS_OFF;
  wire hit_ssel = paddr == STAT_SEL_OFF;
  wire hit_dyn = paddr == DYN_OFF;
  wire hit_fbd = paddr == FBDIV_OFF;
  wire hit_stat = paddr == STATUS_OFF;
  wire mapped = hit_ctrl | hit_sref | hit_sdis | hit_ssel | hit_dyn | hit_fbd | hit_stat | pair_hit;
  wire dyn_wr = wr & hit_dyn;
  wire sync_hi = sync_s | ctrl.sync_soft;
  wire dyn_stall = stall_cnt != 13'h0000;

  wire [31:0] status_word = {19'h00000, dyn_steps, pin1_s, active_input_select,
                             dyn_stall, sync_hi};
  wire [31:0] dyn_word = {9'h000, dyn_mask, 7'h00, 1'b0, dyn_steps};
  wire [31:0] rd_val =
    hit_ctrl ? 32'(ctrl) :
    hit_sref ? 32'(sref) :
    hit_sdis ? {24'h000000, sync_dis} :
    hit_ssel ? {16'h0000, stat_sel} :
    hit_dyn ? dyn_word :
    hit_fbd ? 32'(fbdiv) :
    hit_stat ? status_word :
    pair_hit ? 32'(pair_cfg[pair_idx]) : 32'h0000_0000;

  // answer comes one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      prdata <= (access & ~pready & ~pwrite) ? rd_val : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= cdd_ctrl_t'(CTRL_RST);
      sref <= cdd_sref_t'(SREF_RST);
      sync_dis <= SYNC_DIS_RST[7:0];
      stat_sel <= STAT_SEL_RST[15:0];
      fbdiv <= cdd_fbdiv_t'(FBDIV_RST);
    end else if (wr) begin
      if (hit_ctrl) ctrl <= cdd_ctrl_t'(merge(32'(ctrl), pwdata, pstrb));
      if (hit_sref) sref <= cdd_sref_t'(merge(32'(sref), pwdata, pstrb));
      if (hit_sdis && pstrb[0]) sync_dis <= pwdata[7:0];
      if (hit_ssel) stat_sel <= 16'(merge({16'h0000, stat_sel}, pwdata, pstrb));
      if (hit_fbd) fbdiv <= cdd_fbdiv_t'(merge(32'(fbdiv), pwdata, pstrb));
    end
  end

  // ************************************************************
  // sync and sysref divider
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_prev <= 1'b0;
    end else begin
      sync_prev <= sync_hi;
    end
  end

  wire sync_fall = sync_prev & ~sync_hi;

  cdd_divider #(.W(SREF_DIV_W)) u_sref_div (
    .pclk(pclk),
    .presetn(presetn),
    .hold(sync_hi & ~sync_dis[7]),
    .restart(sync_fall & ~sync_dis[7]),
    .stall(1'b0),
    .dcc(1'b0),
    .div(sref.div),
    .min_div(SREF_DIV_MIN),
    .delay(sref.gddly),
    .out(sysref_raw),
    .wrap(sref_wrap)
  );

  // ************************************************************
  // dynamic digital delay
  // ************************************************************
  wire [12:0] sref_half = sref.div >> 1;
  wire [12:0] stall_len = (sref.gddly > sref_half) ? 13'(sref.gddly - sref_half) : 13'h0001;

  // steps pace on sysref wraps; a held sysref divider stalls the queue
  // paced multi-step adjust
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dyn_steps <= 8'h00;
      dyn_mask <= '0;
      dyn_half_phase <= '0;
      stall_cnt <= 13'h0000;
    end else if (dyn_wr) begin
      dyn_steps <= pwdata[DYN_STEPS_LSB +: 8];
      dyn_mask <= pwdata[DYN_MASK_LSB +: NUM_PAIRS];
      dyn_half_phase <= dyn_half_phase ^
                        (pwdata[DYN_MASK_LSB +: NUM_PAIRS] & {NUM_PAIRS{pwdata[DYN_HALF_BIT]}});
    end else if (!dyn_stall && dyn_steps != 8'h00 && sref_wrap) begin
      stall_cnt <= stall_len;
      dyn_steps <= dyn_steps - 8'h01;
    end else if (dyn_stall) begin
      stall_cnt <= stall_cnt - 13'h0001;
    end
  end

  // ************************************************************
  // output pairs
  // ************************************************************
  // seven paired dividers
  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
    cdd_pair_cfg_t c;
    logic [9:0] ddly_shadow;
    logic [LSREF_TAPS-1:0] sr_pipe;
    logic dclk;
    assign c = pair_cfg[p];

    wire pwr = wr & pair_hit & (pair_idx == 3'(p));
    wire [9:0] ddly_eff = (c.ddly < DDLY_MIN) ? DDLY_MIN : c.ddly;
    wire dhold = sync_hi & ~sync_dis[p];
    wire [3:0] lsel = (c.sref_ddly < LSREF_MIN) ? LSREF_MIN :
                      (c.sref_ddly > LSREF_MAX) ? LSREF_MAX : c.sref_ddly;
    wire sref_loc = sr_pipe[4'(lsel - 4'h1)];
    wire even_sref = c.src_sref_even | (c.jesd & c.sysref_on_even);
    wire odd_sref = c.src_sref_odd | (c.jesd & ~c.sysref_on_even);
    wire even_src = even_sref ? sref_loc : (c.bypass | dclk);
    wire odd_src = odd_sref ? sref_loc : dclk;
    assign dclk_vec[p] = dclk;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pair_cfg[p] <= cdd_pair_cfg_t'(PAIR_RST);
      end else if (pwr) begin
        pair_cfg[p] <= cdd_pair_cfg_t'(merge(32'(pair_cfg[p]), pwdata, pstrb));
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ddly_shadow <= PAIR_RST[25:16];
      end else if (dhold) begin
        ddly_shadow <= ddly_eff;
      end
    end

    cdd_divider #(.W(DCLK_DIV_W)) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .hold(dhold),
      .restart(sync_fall & ~sync_dis[p]),
      .stall(dyn_stall & dyn_mask[p]),
      .dcc(c.dcc),
      .div(c.div),
      .min_div(DCLK_DIV_MIN),
      .delay({3'h0, ddly_shadow}),
      .out(dclk),
      .wrap()
    );

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sr_pipe <= '0;
        clk_out[2*p] <= 1'b0;
        clk_out[2*p+1] <= 1'b0;
        half_step_out[2*p] <= 1'b0;
        half_step_out[2*p+1] <= 1'b0;
      end else begin
        sr_pipe <= {sr_pipe[LSREF_TAPS-2:0], sysref_raw};
        clk_out[2*p] <= even_src;
        clk_out[2*p+1] <= odd_src;
        // half-cycle shift itself is done in the output stage
        half_step_out[2*p] <= even_sref ? c.half : dyn_half_phase[p];
        half_step_out[2*p+1] <= odd_sref ? c.half : dyn_half_phase[p];
      end
    end
  end

  // ************************************************************
  // feedback and zero delay
  // ************************************************************
  logic fb_prev;
  logic [2:0] pre_cnt;
  logic [15:0] n_cnt;

  wire fb_cur = (ctrl.fb == FB_OUT6) ? clk_out[6] :
                (ctrl.fb == FB_OUT8) ? clk_out[8] :
                (ctrl.fb == FB_SYSREF) ? sysref_raw : ext_fb_s;
  wire fb_edge = fb_cur & ~fb_prev;
  wire fb_tick = (ctrl.zd == ZD_CASCADED) ? fb_edge : 1'b1;
  wire [2:0] presc = (fbdiv.presc < PRESC_MIN) ? PRESC_MIN : fbdiv.presc;
  wire [15:0] n_eff = (fbdiv.n < FBN_MIN) ? FBN_MIN : fbdiv.n;
  wire pre_wrap = fb_tick & (pre_cnt == 3'(presc - 3'h1));
  wire n_wrap = pre_wrap & (n_cnt == 16'(n_eff - 16'h0001));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_prev <= 1'b0;
      pre_cnt <= 3'h0;
      n_cnt <= 16'h0000;
      second_loop_fb_out <= 1'b0;
      first_loop_fb_out <= 1'b0;
    end else begin
      fb_prev <= fb_cur;
      if (fb_tick) pre_cnt <= pre_wrap ? 3'h0 : 3'(pre_cnt + 3'h1);
      if (pre_wrap) n_cnt <= n_wrap ? 16'h0000 : 16'(n_cnt + 16'h0001);
      // cascaded to second loop, nested to first
      second_loop_fb_out <= n_wrap;
      first_loop_fb_out <= (ctrl.zd == ZD_NESTED) & fb_edge;
    end
  end

  // ************************************************************
  // reference buffer and status pins
  // ************************************************************
  // reference buffer source
  wire refbuf_src = (ctrl.refbuf == RB_OSC) ? osc_s :
                    (ctrl.refbuf == RB_DCLK6) ? dclk_vec[3] :
                    (ctrl.refbuf == RB_DCLK8) ? dclk_vec[4] : sysref_raw;
  wire [15:0] stat_src = {6'h00, second_loop_fb_out, ctrl.readback, vtune_s, dclk_vec[3],
                          sysref_raw, lock1_s & lock2_s, lock2_s, lock1_s, los_s, 1'b0};
  wire [1:0] next_input_select = ctrl.pin1_input ? {1'b0, pin1_s} : ctrl.ref_sel;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_buffer_output <= 1'b0;
      input_select_pin_zero <= 1'b0;
      lock_status_pin_one <= 1'b0;
      lock_status_pin_two <= 1'b0;
      input_select_pin_one_o <= 1'b0;
      input_select_pin_one_oe <= 1'b0;
      active_input_select <= 2'h0;
    end else begin
      reference_buffer_output <= refbuf_src;
      input_select_pin_zero <= stat_src[stat_sel[3:0]];
      lock_status_pin_one <= stat_src[stat_sel[7:4]];
      lock_status_pin_two <= stat_src[stat_sel[11:8]];
      input_select_pin_one_o <= stat_src[stat_sel[15:12]];
      input_select_pin_one_oe <= ~ctrl.pin1_input;
      active_input_select <= next_input_select;
    end
  end

endmodule // cdd_clock_dist
`default_nettype wire

// file: rtl/cdd_pkg.sv
`default_nettype none
package cdd_pkg;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int unsigned NUM_PAIRS = 7;
  localparam int unsigned NUM_OUTS = 14;
  localparam int unsigned DCLK_DIV_W = 10;
  localparam int unsigned SREF_DIV_W = 13;
  localparam int unsigned LSREF_TAPS = 11;

  // ************************************************************
  // limits and counts
  // ************************************************************
  localparam logic [9:0] DCLK_DIV_MIN = 10'h001;
  localparam logic [9:0] DDLY_MIN = 10'h008;
  localparam logic [12:0] SREF_DIV_MIN = 13'h0008;
  localparam logic [3:0] LSREF_MIN = 4'h1;
  localparam logic [3:0] LSREF_MAX = 4'hb;
  localparam logic [2:0] PRESC_MIN = 3'h2;
  localparam logic [15:0] FBN_MIN = 16'h0001;

  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] SREF_OFF = 8'h04;
  localparam logic [7:0] SYNC_DIS_OFF = 8'h08;
  localparam logic [7:0] STAT_SEL_OFF = 8'h0c;
  localparam logic [7:0] DYN_OFF = 8'h10;
  localparam logic [7:0] FBDIV_OFF = 8'h14;
  localparam logic [7:0] STATUS_OFF = 8'h18;
  localparam logic [2:0] PAIR_PAGE = 3'h1;

  // dynamic delay request fields
  localparam int unsigned DYN_STEPS_LSB = 0;
  localparam int unsigned DYN_HALF_BIT = 8;
  localparam int unsigned DYN_MASK_LSB = 16;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SREF_RST = 32'h0000_0100;
  localparam logic [31:0] SYNC_DIS_RST = 32'h0000_0000;
  localparam logic [31:0] STAT_SEL_RST = 32'h0000_0341;
  localparam logic [31:0] FBDIV_RST = 32'h0001_0002;
  localparam logic [31:0] PAIR_RST = 32'h0408_0008;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {ZD_OFF, ZD_CASCADED, ZD_NESTED} cdd_zd_mode_t;
  typedef enum logic [1:0] {FB_OUT6, FB_OUT8, FB_SYSREF, FB_EXTERNAL} cdd_fb_sel_t;
  typedef enum logic [1:0] {RB_OSC, RB_DCLK6, RB_DCLK8, RB_SYSREF} cdd_refbuf_sel_t;

  typedef struct packed {
    logic [20:0] pad;
    logic readback;
    logic [1:0] ref_sel;
    logic pin1_input;
    cdd_refbuf_sel_t refbuf;
    cdd_fb_sel_t fb;
    cdd_zd_mode_t zd;
    logic sync_soft;
  } cdd_ctrl_t;

  typedef struct packed {
    logic [2:0] pad_hi;
    logic [12:0] gddly;
    logic [2:0] pad_lo;
    logic [12:0] div;
  } cdd_sref_t;

  typedef struct packed {
    logic [15:0] n;
    logic [12:0] pad;
    logic [2:0] presc;
  } cdd_fbdiv_t;

  typedef struct packed {
    logic pad;
    logic half;
    logic [3:0] sref_ddly;
    logic [9:0] ddly;
    logic jesd;
    logic src_sref_odd;
    logic src_sref_even;
    logic sysref_on_even;
    logic bypass;
    logic dcc;
    logic [9:0] div;
  } cdd_pair_cfg_t;

endpackage
`default_nettype wire

// file: rtl/cdd_divider.sv
`timescale 1ns/100ps
`default_nettype none
module cdd_divider
  import cdd_pkg::*;
#(
  parameter int unsigned W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hold,
  input wire logic restart,
  input wire logic stall,
  input wire logic dcc,
  input wire logic [W-1:0] div,
  input wire logic [W-1:0] min_div,
  input wire logic [12:0] delay,
  output logic out,
  output logic wrap
);

  logic [W-1:0] cnt;
  logic [12:0] dly;

  wire [W-1:0] eff = (div < min_div) ? min_div : div;
  wire [W:0] eff_up = {1'b0, eff} + {{W{1'b0}}, 1'b1};
  // odd ratios: correction rounds the high time up
  wire [W-1:0] high = dcc ? eff_up[W:1] : (eff >> 1);
  wire last = (cnt == W'(eff - {{(W-1){1'b0}}, 1'b1}));
  wire running = ~hold & (dly == 13'h0000);
  assign wrap = running & last & ~stall;

  // ************************************************************
  // counter
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      dly <= 13'h0000;
      out <= 1'b0;
    end else if (hold) begin
      cnt <= '0;
      dly <= 13'h0000;
      out <= 1'b0;
    end else if (restart) begin
      // start phase waits out the delay so all edges line up
      cnt <= '0;
      dly <= delay;
      out <= 1'b0;
    end else if (dly != 13'h0000) begin
      dly <= dly - 13'h0001;
    end else if (!stall) begin
      cnt <= last ? '0 : W'(cnt + {{(W-1){1'b0}}, 1'b1});
      // ratio one: level high means full-rate clock passes
      out <= (eff == min_div && eff == {{(W-1){1'b0}}, 1'b1}) | (cnt < high);
    end
  end

endmodule // cdd_divider
`default_nettype wire

// file: tb/cdd_sva.sv
`timescale 1ns/100ps
`default_nettype none
module cdd_sva
  import cdd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_OUTS-1:0] half_step_out,
  input wire logic second_loop_fb_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  logic dyn_wr;
  // ************************************************************
  // decode helpers
  // ************************************************************
  assign mapped = (paddr[1:0] == 2'h0) && ((paddr <= STATUS_OFF) ||
                  (paddr >= 8'h20 && paddr <= 8'h38));
  assign dyn_wr = psel && penable && pready && pwrite && paddr == DYN_OFF &&
                  pwdata[DYN_HALF_BIT] && |pwdata[22:16] && pstrb == 4'hf;
  // ************************************************************
  // properties
  // ************************************************************
  property p_ready_setup;
    psel && !penable |=> !pready;
  endproperty
  a_ready_setup: assert property (p_ready_setup) else $error("ready in setup");
  property p_ready_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("ready late");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  property p_ready_access;
    pready |-> psel && penable;
  endproperty
  a_ready_access: assert property (p_ready_access) else $error("ready outside access");
  property p_err_map;
    pready |-> pslverr == !mapped;
  endproperty
  a_err_map: assert property (p_err_map) else $error("error flag wrong");
  property p_rdata_idle;
    !pready |-> prdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
  property p_err_rdata;
    pready && pslverr |-> prdata == 32'h0000_0000;
  endproperty
  a_err_rdata: assert property (p_err_rdata) else $error("refused read data");
  property p_fb_pulse;
    second_loop_fb_out |=> !second_loop_fb_out;
  endproperty
  a_fb_pulse: assert property (p_fb_pulse) else $error("feedback pulse long");
  property p_half;
    dyn_wr |=> ##[0:2] $changed(half_step_out);
  endproperty
  a_half: assert property (p_half) else $error("half step missing");
  c_write: cover property (psel && penable && pready && pwrite);
  c_refused: cover property (pready && pslverr);
  c_half: cover property (dyn_wr);
endmodule // cdd_sva
bind cdd_clock_dist cdd_sva u_sva (.*);
`default_nettype wire

// file: tb/cdd_sink.sv
`timescale 1ns/100ps
`default_nettype none
module cdd_sink (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [13:0] clk_out,
  input wire logic [3:0] sel,
  input wire logic clr,
  output logic [15:0] rises
);
  logic last;
  // ************************************************************
  // receiver edge counter, one watched output
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last <= 1'b0;
      rises <= 16'h0000;
    end else begin
      last <= clk_out[sel];
      if (clr) rises <= 16'h0000;
      else if (clk_out[sel] && !last) rises <= rises + 16'h0001;
    end
  end
endmodule // cdd_sink
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import cdd_pkg::*;
  logic pclk, presetn, psel = 0, penable = 0, pwrite = 0, sync_pin = 0, clr = 0;
  logic loss_of_signal = 0, first_loop_lock = 0, second_loop_lock = 0;
  logic input_select_pin_one_i = 0, vtune_rail = 0, oscillator_reference_input = 0;
  logic first_loop_reference_input = 0, external_feedback_input = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 4'hf, sel = 0;
  logic pready, pslverr, err, input_select_pin_one_o, input_select_pin_one_oe;
  logic input_select_pin_zero, lock_status_pin_one, lock_status_pin_two;
  logic reference_buffer_output, second_loop_fb_out, first_loop_fb_out, ok;
  logic [1:0] active_input_select;
  logic [13:0] clk_out, half_step_out;
  logic [15:0] rises;
  int n_errors = 0, compares = 0;
  cdd_clock_dist u_dut (.*);
  cdd_sink u_sink (.*);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ************************************************************
  // shared tasks
  // ************************************************************
  task results;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    logic seen;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    // ready, data and error all taken at the rising edge that ends the access
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    seen = pready;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (seen !== 1'b1) begin
      n_errors++;
      $display("[FAIL] apb wait exp ready got timeout");
      results();
    end
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic same(input int n, input logic inv);
    ok = 1'b1;
    repeat (n) begin
      @(negedge pclk);
      if (clk_out[8] !== (clk_out[4] ^ inv)) ok = 1'b0;
    end
    @(posedge pclk);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task t_regs;
    rdc("ctrl", CTRL_OFF, CTRL_RST);
    rdc("sync_dis", SYNC_DIS_OFF, SYNC_DIS_RST);
    rdc("stat_sel", STAT_SEL_OFF, STAT_SEL_RST);
    rdc("fbdiv", FBDIV_OFF, FBDIV_RST);
    rdc("pair6", 8'h38, PAIR_RST);
    apb(1'b1, SREF_OFF, 32'h0000_1fff);
    rdc("sref max", SREF_OFF, 32'h0000_1fff);
    apb(1'b1, 8'h1c, 32'hffff_ffff);
    chk("wr unmapped", 32'h1, 32'(err));
    rdc("rd unmapped", 8'h3c, 32'h0);
    $display("test regs done");
  endtask
  task t_status;
    int n;
    loss_of_signal <= 1'b1;
    second_loop_lock <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("pin zero", 32'h1, 32'(input_select_pin_zero));
    chk("ld2", 32'h1, 32'(lock_status_pin_two));
    chk("ld1 one lock", 32'h0, 32'(lock_status_pin_one));
    first_loop_lock <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("ld1 both", 32'h1, 32'(lock_status_pin_one));
    apb(1'b1, CTRL_OFF, 32'h0000_0080);
    input_select_pin_one_i <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("pin1 oe", 32'h0, 32'(input_select_pin_one_oe));
    chk("pin1 select", 32'h1, 32'(active_input_select));
    // nested zero delay on the external feedback pin, pin one back to output
    apb(1'b1, CTRL_OFF, 32'h0000_001c);
    apb(1'b1, STAT_SEL_OFF, 32'h0000_2341);
    oscillator_reference_input <= 1'b1;
    external_feedback_input <= 1'b1;
    n = 0;
    repeat (5) begin
      @(posedge pclk);
      if (first_loop_fb_out === 1'b1) n++;
    end
    chk("nested fb pulse", 32'h1, 32'(n));
    chk("pin1 out", 32'h3, {30'h0, input_select_pin_one_o, input_select_pin_one_oe});
    chk("refbuf osc", 32'h1, 32'(reference_buffer_output));
    apb(1'b1, CTRL_OFF, 32'h0);
    $display("test status done");
  endtask
  task t_bypass;
    apb(1'b1, 8'h20, 32'h0408_0808);
    apb(1'b1, 8'h24, 32'h0408_0001);
    // new ratio reaches the pin two edges after the write
    repeat (2) @(posedge pclk);
    ok = 1'b1;
    repeat (8) begin
      @(negedge pclk);
      if (clk_out[0] !== 1'b1 || clk_out[2] !== 1'b1) ok = 1'b0;
    end
    @(posedge pclk);
    chk("bypass and ratio one", 32'h1, 32'(ok));
    $display("test bypass done");
  endtask
  task t_sync;
    apb(1'b1, 8'h28, 32'h0408_0004);
    apb(1'b1, 8'h30, 32'h0408_0004);
    apb(1'b1, SYNC_DIS_OFF, 32'h0000_0008);
    sync_pin <= 1'b1;
    sel <= 4'h6;
    repeat (6) @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    same(64, 1'b0);
    chk("held pairs low", 32'h0, {30'h0, clk_out[5:4]});
    chk("free pair runs", 32'h1, 32'(rises > 16'h0));
    sync_pin <= 1'b0;
    sel <= 4'h4;
    repeat (20) @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    same(40, 1'b0);
    chk("common edge", 32'h1, 32'(ok));
    chk("divide four", 32'h1, 32'(rises >= 16'd9 && rises <= 16'd11));
    apb(1'b1, 8'h30, 32'h040a_0004);
    same(20, 1'b0);
    chk("delay waits sync", 32'h1, 32'(ok));
    sync_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    sync_pin <= 1'b0;
    repeat (24) @(posedge pclk);
    same(20, 1'b1);
    chk("delay two cycles", 32'h1, 32'(ok));
    $display("test sync done");
  endtask
  task t_dyn;
    int n;
    // one cycle step: half the sysref ratio plus one
    apb(1'b1, SREF_OFF, 32'h0081_0100);
    apb(1'b1, DYN_OFF, 32'h0001_0100);
    @(posedge pclk);
    chk("half step", 32'h1, 32'(half_step_out[0]));
    apb(1'b1, DYN_OFF, 32'h0020_0001);
    repeat (700) @(posedge pclk);
    apb(1'b0, DYN_OFF, 32'h0);
    chk("steps done", 32'h0, {24'h0, rd[7:0]});
    n = 0;
    repeat (100) begin
      @(negedge pclk);
      if (second_loop_fb_out === 1'b1) n++;
    end
    @(posedge pclk);
    chk("fb pulses", 32'h1, 32'(n >= 49 && n <= 51));
    $display("test dynamic done");
  endtask
  initial begin
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_status();
    t_bypass();
    t_sync();
    t_dyn();
    results();
  end
endmodule // tb
`default_nettype wire
